// ---- hw/iox_mst_end.sv ----
`timescale 1ns/1ps
`include "iox_regs.svh"
module iox_mst_end
	import iox_pkg::*;
#(
	parameter int QTR_CYC = `IOX_QTR_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	iox_i2c_if.mst bus
);

	if (QTR_CYC < 1 || QTR_CYC > 255) begin : g_chk
		$error("iox_mst_end quarter period must be 1 to 255 cycles");
	end

	localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

	localparam iox_mst_st_type MST_RST = '{
		state: M_IDLE,
		qcnt: 8'h00,
		qtr: 2'h0,
		bitn: 4'h0,
		tx: 9'h1FF,
		rx: 9'h000,
		step: 3'h0,
		op: OP_WRITE,
		asel: 1'b0,
		cmd: 8'h00,
		wdata: 8'h00,
		rdata: 8'h00,
		busy: 1'b0,
		nack: 1'b0,
		scl_oe: 1'b0,
		sda_oe: 1'b0,
		a_act: 1'b0,
		a_wr: 1'b0,
		a_addr: 8'h00,
		hrdata: 32'h0000_0000
	};

	iox_mst_st_type q;
	iox_mst_st_type d;
	logic tick;

	// write then restart for a commanded read; reuse selector
	function automatic iox_item_type item_at(input iox_op_type op, input logic [2:0] step);
		iox_item_type it;
		it = IT_STOP;
		unique case (op)
			OP_READ_CMD: begin
				unique case (step)
					3'h0: it = IT_START;
					3'h1: it = IT_ADDR_W;
					3'h2: it = IT_CMD;
					3'h3: it = IT_START;
					3'h4: it = IT_ADDR_R;
					3'h5: it = IT_RX;
					default: it = IT_STOP;
				endcase
			end
			OP_READ_CUR: begin
				unique case (step)
					3'h0: it = IT_START;
					3'h1: it = IT_ADDR_R;
					3'h2: it = IT_RX;
					default: it = IT_STOP;
				endcase
			end
			default: begin
				unique case (step)
					3'h0: it = IT_START;
					3'h1: it = IT_ADDR_W;
					3'h2: it = IT_CMD;
					3'h3: it = IT_DATA;
					default: it = IT_STOP;
				endcase
			end
		endcase
		return it;
	endfunction

	function automatic iox_mst_st_type load_item(input iox_mst_st_type s);
		iox_mst_st_type r;
		r = s;
		r.qcnt = 8'h00;
		r.qtr = 2'h0;
		r.bitn = 4'h0;
		r.state = M_BITS;
		unique case (item_at(s.op, s.step))
			IT_START: r.state = M_START;
			IT_STOP: r.state = M_STOP;
			IT_ADDR_W: r.tx = {`IOX_ADDR_HI, s.asel, 1'b0, 1'b1};
			IT_ADDR_R: r.tx = {`IOX_ADDR_HI, s.asel, 1'b1, 1'b1};
			IT_CMD: r.tx = {s.cmd, 1'b1};
			IT_DATA: r.tx = {s.wdata, 1'b1};
			// single byte read ends in nack
			default: r.tx = 9'h1FF;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] reg_read(input iox_mst_st_type s, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (a)
			`IOX_A_CTRL: r = {29'h0, s.asel, s.op};
			`IOX_A_CMD: r = {24'h0, s.cmd};
			`IOX_A_WDATA: r = {24'h0, s.wdata};
			`IOX_A_RDATA: r = {24'h0, s.rdata};
			`IOX_A_STATUS: r = {30'h0, s.nack, s.busy};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	assign tick = (q.qcnt == QTR_LAST);

	always_comb begin
		d = q;
		d.a_act = 1'b0;
		if (hsel && htrans[1] && hready) begin
			d.a_act = 1'b1;
			d.a_wr = hwrite;
			d.a_addr = haddr[7:0];
			d.hrdata = reg_read(q, haddr[7:0]);
		end
		if (q.a_act && q.a_wr) begin
			unique case (q.a_addr)
				`IOX_A_CMD: d.cmd = hwdata[7:0];
				`IOX_A_WDATA: d.wdata = hwdata[7:0];
				`IOX_A_CTRL: begin
					// ignored while a transfer runs
					if (!q.busy) begin
						d.op = iox_op_type'(hwdata[`IOX_CTRL_OP_LSB +: 2]);
						d.asel = hwdata[`IOX_CTRL_ASEL_BIT];
						d.busy = 1'b1;
						d.nack = 1'b0;
						d.step = 3'h0;
						d = load_item(d);
					end
				end
				default: d.cmd = q.cmd;
			endcase
		end
		if (q.state != M_IDLE) begin
			d.qcnt = tick ? 8'h00 : q.qcnt + 8'h01;
		end
		if (tick) begin
			d.qtr = q.qtr + 2'h1;
			unique case (q.state)
				M_START: begin
					unique case (q.qtr)
						2'h0: d.sda_oe = 1'b0;
						2'h1: d.scl_oe = 1'b0;
						2'h2: d.sda_oe = 1'b1;
						default: begin
							d.scl_oe = 1'b1;
							d.step = q.step + 3'h1;
							d = load_item(d);
						end
					endcase
				end
				M_BITS: begin
					unique case (q.qtr)
						// released for the device when tx bit is one
						2'h0: d.sda_oe = ~q.tx[8];
						2'h1: d.scl_oe = 1'b0;
						2'h2: d.rx = {q.rx[7:0], bus.sda};
						default: begin
							d.scl_oe = 1'b1;
							d.tx = {q.tx[7:0], 1'b1};
							d.bitn = q.bitn + 4'h1;
							if (q.bitn == 4'h8) begin
								d.step = q.step + 3'h1;
								if (item_at(q.op, q.step) == IT_RX) begin
									d.rdata = q.rx[8:1];
									d = load_item(d);
								end else if (q.rx[0]) begin
									d.nack = 1'b1;
									d.qcnt = 8'h00;
									d.qtr = 2'h0;
									d.state = M_STOP;
								end else begin
									d = load_item(d);
								end
							end
						end
					endcase
				end
				M_STOP: begin
					unique case (q.qtr)
						2'h0: d.sda_oe = 1'b1;
						2'h1: d.scl_oe = 1'b0;
						2'h2: d.sda_oe = 1'b0;
						default: begin
							d.state = M_IDLE;
							d.busy = 1'b0;
						end
					endcase
				end
				default: d.qtr = 2'h0;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= MST_RST;
		end else begin
			q <= d;
		end
	end

	// zero wait state slave, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.hrdata;
	assign bus.scl_oe_m = q.scl_oe;
	assign bus.sda_oe_m = q.sda_oe;

endmodule

// ---- shared/iox_regs.svh ----
`ifndef IOX_REGS_SVH
`define IOX_REGS_SVH

// expander register selectors
`define IOX_SEL_SNAP 8'h00
`define IOX_SEL_OUT 8'h01
`define IOX_SEL_INV 8'h02
`define IOX_SEL_DIR 8'h03

// expander reset values
`define IOX_RST_OUT 8'hFF
`define IOX_RST_INV 8'h00
`define IOX_RST_DIR 8'hFF
`define IOX_RST_SEL 8'h00

// upper six bits of the slave address, strap gives bit 0
`define IOX_ADDR_HI 6'h10

// serial clock timing
`define IOX_CLK_KHZ 125000
`define IOX_SCL_KHZ 400
`define IOX_QTR_CYC (`IOX_CLK_KHZ / (`IOX_SCL_KHZ * 4))

// controller register offsets
`define IOX_A_CTRL 8'h00
`define IOX_A_CMD 8'h04
`define IOX_A_WDATA 8'h08
`define IOX_A_RDATA 8'h0C
`define IOX_A_STATUS 8'h10

// controller field positions
`define IOX_CTRL_OP_LSB 0
`define IOX_CTRL_ASEL_BIT 2
`define IOX_ST_BUSY_BIT 0
`define IOX_ST_NACK_BIT 1

`endif

// ---- shared/iox_pkg.sv ----
package iox_pkg;

	typedef enum logic [4:0] {
		D_IDLE = 5'h01,
		D_RX = 5'h02,
		D_ACK = 5'h04,
		D_TX = 5'h08,
		D_MACK = 5'h10
	} iox_dev_state_type;

	typedef enum logic [1:0] {
		PH_ADDR = 2'h0,
		PH_CMD = 2'h1,
		PH_DATA = 2'h2
	} iox_phase_type;

	typedef enum logic [3:0] {
		M_IDLE = 4'h1,
		M_START = 4'h2,
		M_BITS = 4'h4,
		M_STOP = 4'h8
	} iox_mst_state_type;

	// controller operations
	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_READ_CMD = 2'h1,
		OP_READ_CUR = 2'h2
	} iox_op_type;

	typedef enum logic [2:0] {
		IT_START = 3'h0,
		IT_ADDR_W = 3'h1,
		IT_ADDR_R = 3'h2,
		IT_CMD = 3'h3,
		IT_DATA = 3'h4,
		IT_RX = 3'h5,
		IT_STOP = 3'h6
	} iox_item_type;

	typedef struct packed {
		iox_dev_state_type state;
		iox_phase_type phase;
		logic scl_prev;
		logic sda_prev;
		logic [7:0] shift;
		logic [3:0] bitcnt;
		logic rw;
		logic mack;
		logic sda_oe;
		logic [7:0] sel;
		logic [7:0] out_latch;
		logic [7:0] inv;
		logic [7:0] dir;
	} iox_dev_st_type;

	typedef struct packed {
		iox_mst_state_type state;
		logic [7:0] qcnt;
		logic [1:0] qtr;
		logic [3:0] bitn;
		logic [8:0] tx;
		logic [8:0] rx;
		logic [2:0] step;
		iox_op_type op;
		logic asel;
		logic [7:0] cmd;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic busy;
		logic nack;
		logic scl_oe;
		logic sda_oe;
		logic a_act;
		logic a_wr;
		logic [7:0] a_addr;
		logic [31:0] hrdata;
	} iox_mst_st_type;

endpackage

// ---- shared/iox_i2c_if.sv ----
`timescale 1ns/1ps
interface iox_i2c_if;
	logic scl_oe_m;
	logic sda_oe_m;
	logic sda_oe_d;
	logic scl;
	logic sda;

	// open drain with pull-ups: any enabled driver pulls low
	assign scl = ~scl_oe_m;
	assign sda = ~(sda_oe_m | sda_oe_d);

	modport dev (
		input scl,
		input sda,
		output sda_oe_d
	);

	modport mst (
		input scl,
		input sda,
		output scl_oe_m,
		output sda_oe_m
	);
endinterface

// ---- hw/iox_dev_end.sv ----
// Notes on behaviour
// - master writes command before reading
// - repeated start, address with read bit
// - device acks read, then transmits bytes
// - master ack asks for another byte
// - master nack: device releases data line
// - stop anytime; acked data stays valid
// - selector kept across transfers
// - address 0x20 or 0x21 by strap
// - address lsb: 1 read, 0 write
// - first written byte loads selector
// - read phase never changes selector
// - selectors 00..03 pick four registers
// - selector is written over the bus
// - snapshot shows all pin levels
// - snapshot write acked, no effect
// - snapshot has no reset value
// - latch drives output pins, resets ones
// - latch read returns stored value
// - invert mask flips inputs, resets zeros
// - direction one means input, resets ones
// - write: address, command, data, stop
// - reset pin low holds defaults
`timescale 1ns/1ps
`include "iox_regs.svh"
module iox_dev_end
	import iox_pkg::*;
#(
	parameter int PORT_W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic exp_rst_n,
	input wire logic addr_strap,
	input wire logic [PORT_W-1:0] port_in,
	output logic [PORT_W-1:0] port_out,
	output logic [PORT_W-1:0] port_oe,
	iox_i2c_if.dev bus
);

	if (PORT_W != 8) begin : g_chk
		$error("iox_dev_end serves eight pins only");
	end

	localparam iox_dev_st_type DEV_RST = '{
		state: D_IDLE,
		phase: PH_ADDR,
		scl_prev: 1'b1,
		sda_prev: 1'b1,
		shift: 8'h00,
		bitcnt: 4'h0,
		rw: 1'b0,
		mack: 1'b0,
		sda_oe: 1'b0,
		sel: `IOX_RST_SEL,
		out_latch: `IOX_RST_OUT,
		inv: `IOX_RST_INV,
		dir: `IOX_RST_DIR
	};

	iox_dev_st_type q;
	iox_dev_st_type d;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	// byte handed to the master for the selected register
	function automatic logic [7:0] read_mux(input iox_dev_st_type s,
		input logic [7:0] pins);
		logic [7:0] r;
		r = 8'h00;
		unique case (s.sel)
			`IOX_SEL_SNAP: r = pins ^ s.inv;
			`IOX_SEL_OUT: r = s.out_latch;
			`IOX_SEL_INV: r = s.inv;
			`IOX_SEL_DIR: r = s.dir;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	assign scl_rise = bus.scl & ~q.scl_prev;
	assign scl_fall = ~bus.scl & q.scl_prev;
	assign start_seen = q.scl_prev & bus.scl & q.sda_prev & ~bus.sda;
	assign stop_seen = q.scl_prev & bus.scl & ~q.sda_prev & bus.sda;

	always_comb begin
		d = q;
		d.scl_prev = bus.scl;
		d.sda_prev = bus.sda;
		if (start_seen) begin
			d.state = D_RX;
			d.phase = PH_ADDR;
			d.bitcnt = 4'h0;
			d.sda_oe = 1'b0;
		end else if (stop_seen) begin
			d.state = D_IDLE;
			d.sda_oe = 1'b0;
		end else begin
			unique case (q.state)
				D_IDLE: begin
				end
				D_RX: begin
					if (scl_rise) begin
						d.shift = {q.shift[6:0], bus.sda};
						d.bitcnt = q.bitcnt + 4'h1;
					end else if (scl_fall && q.bitcnt == 4'h8) begin
						d.bitcnt = 4'h0;
						d.state = D_ACK;
						d.sda_oe = 1'b1;
						unique case (q.phase)
							PH_ADDR: begin
								if (q.shift[7:1] != {`IOX_ADDR_HI, addr_strap}) begin
									d.state = D_IDLE;
									d.sda_oe = 1'b0;
								end
								d.rw = q.shift[0];
							end
							PH_CMD: begin
								d.sel = q.shift;
							end
							default: begin
								unique case (q.sel)
									`IOX_SEL_OUT: d.out_latch = q.shift;
									`IOX_SEL_INV: d.inv = q.shift;
									`IOX_SEL_DIR: d.dir = q.shift;
									default: d.sel = q.sel;
								endcase
							end
						endcase
					end
				end
				D_ACK: begin
					if (scl_fall) begin
						d.sda_oe = 1'b0;
						d.bitcnt = 4'h0;
						if (q.rw) begin
							d.state = D_TX;
							d.shift = read_mux(q, port_in);
							d.sda_oe = ~d.shift[7];
						end else begin
							d.state = D_RX;
							d.phase = (q.phase == PH_ADDR) ? PH_CMD : PH_DATA;
						end
					end
				end
				D_TX: begin
					if (scl_fall) begin
						if (q.bitcnt == 4'h7) begin
							d.sda_oe = 1'b0;
							d.state = D_MACK;
						end else begin
							d.shift = {q.shift[6:0], 1'b0};
							d.sda_oe = ~q.shift[6];
							d.bitcnt = q.bitcnt + 4'h1;
						end
					end
				end
				D_MACK: begin
					if (scl_rise) begin
						d.mack = ~bus.sda;
					end else if (scl_fall) begin
						d.bitcnt = 4'h0;
						if (q.mack) begin
							d.state = D_TX;
							d.shift = read_mux(q, port_in);
							d.sda_oe = ~d.shift[7];
						end else begin
							d.state = D_IDLE;
							d.sda_oe = 1'b0;
						end
					end
				end
				default: begin
					d.state = D_IDLE;
					d.sda_oe = 1'b0;
				end
			endcase
		end
		if (!exp_rst_n) begin
			d = DEV_RST;
		end
	end

	// selector only changes on a command byte or an expander reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= DEV_RST;
		end else begin
			q <= d;
		end
	end

	// latch reaches pins only where configured output
	assign port_out = q.out_latch;
	assign port_oe = ~q.dir;
	assign bus.sda_oe_d = q.sda_oe;

endmodule

// ---- verif/iox_link_chk.sv ----
`timescale 1ns/1ps
`include "iox_regs.svh"
module iox_link_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic addr_strap,
	input wire logic sda_oe_d,
	input wire logic scl,
	input wire logic sda
);
	logic scl_q, sda_q, rw_q, am_q;
	logic [3:0] fc_q, nb_q;
	logic [7:0] sh_q;
	logic rise, fall, start, stop;
	// edges seen against last cycle, as the device sees them
	assign rise = scl && !scl_q;
	assign fall = !scl && scl_q;
	assign start = scl && scl_q && sda_q && !sda;
	assign stop = scl && scl_q && !sda_q && sda;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{scl_q, sda_q, rw_q, am_q, fc_q, nb_q, sh_q} <= {2'b11, 18'h0};
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (rise) begin
				sh_q <= {sh_q[6:0], sda};
			end
			if (rise && fc_q == 4'h8 && nb_q == 4'h0) begin
				rw_q <= sda;
				am_q <= sh_q[6:0] == {`IOX_ADDR_HI, addr_strap};
			end
			if (start) begin
				fc_q <= 4'h0;
				nb_q <= 4'h0;
			end else if (fall) begin
				fc_q <= (fc_q == 4'h9) ? 4'h1 : fc_q + 4'h1;
				nb_q <= nb_q + {3'h0, fc_q == 4'h9};
			end
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sda_hold_a: assert property (scl && scl_q |-> $stable(sda_oe_d))
		else $error("device data moved while clock high");
	addr_quiet_a: assert property (
		fc_q > 4'h1 && fc_q < 4'h9 && (nb_q == 4'h0 || !rw_q) |-> !sda_oe_d)
		else $error("device drove data while receiving");
	addr_ack_a: assert property (rise && fc_q == 4'h9 && nb_q == 4'h0 |-> sda_oe_d == am_q)
		else $error("address ack does not match strap");
	byte_ack_a: assert property (
		rise && fc_q == 4'h9 && nb_q != 4'h0 && !rw_q && am_q |-> sda_oe_d)
		else $error("written byte not acked");
	nack_free_a: assert property (
		fall && fc_q == 4'h9 && nb_q != 4'h0 && rw_q && sda |=> !sda_oe_d [*8])
		else $error("device kept data line after nack");
	nomatch_quiet_a: assert property (nb_q != 4'h0 && !am_q |-> !sda_oe_d)
		else $error("device drove line for other address");
	stop_idle_a: assert property (stop |-> scl [*8])
		else $error("clock moved right after stop");
	start_clock_a: assert property (start |-> ##[1:40] !scl)
		else $error("no clock after start");
endmodule

// ---- verif/tb_i2c_eight_bit_io_expander.sv ----
`timescale 1ns/1ps
`include "iox_regs.svh"
`define CHK(nm, e, g) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("[ERR] %s exp %h got %h", nm, (e), (g)); \
	end \
end
module tb_i2c_eight_bit_io_expander
	import iox_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, exp_rst_n, addr_strap;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic hreadyout, hresp;
	logic [7:0] ext, port_in, port_out, port_oe;
	logic [7:0] wv [4] = '{8'h00, 8'hA5, 8'h5A, 8'h0F};
	int mismatches = 0;
	int n_checks = 0;
	iox_i2c_if link();
	// pin level: driven bits follow the latch, the rest the outside world
	assign port_in = (port_oe & port_out) | (~port_oe & ext);
	// quarter of 4 clocks keeps runs short, still above the edge-sense minimum
	iox_mst_end #(.QTR_CYC(4)) u_iox_mst_end (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .bus(link));
	iox_dev_end u_iox_dev_end (.hclk(hclk), .hresetn(hresetn), .exp_rst_n(exp_rst_n),
		.addr_strap(addr_strap), .port_in(port_in), .port_out(port_out), .port_oe(port_oe),
		.bus(link));
	iox_link_chk u_iox_link_chk (.hclk(hclk), .hresetn(hresetn), .addr_strap(addr_strap),
		.sda_oe_d(link.sda_oe_d), .scl(link.scl), .sda(link.sda));
	always #4 hclk = ~hclk;
	task automatic close_out();
		if (mismatches == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask
	task automatic xfer(input iox_op_type op, input logic as, input logic [7:0] cmd,
		input logic [7:0] wd, input logic nk, input logic [7:0] exp);
		logic [31:0] r;
		int n;
		bus(1'b1, `IOX_A_CMD, {24'h0, cmd}, r);
		bus(1'b1, `IOX_A_WDATA, {24'h0, wd}, r);
		bus(1'b1, `IOX_A_CTRL, {29'h0, as, op}, r);
		n = 0;
		// busy is polled; the controller refuses a start while busy
		do begin
			bus(1'b0, `IOX_A_STATUS, 32'h0, r);
			n++;
		end while (r[`IOX_ST_BUSY_BIT] !== 1'b0 && n < 5000);
		`CHK("busy", 1'b0, r[`IOX_ST_BUSY_BIT])
		`CHK("nack", nk, r[`IOX_ST_NACK_BIT])
		if (op != OP_WRITE) begin
			bus(1'b0, `IOX_A_RDATA, 32'h0, r);
			`CHK("rdata", exp, r[7:0])
		end
	endtask
	initial begin
		#400000;
		mismatches++;
		close_out();
	end
	initial begin
		hclk = 1'b0;
		{hresetn, hwrite, htrans, haddr, hwdata, addr_strap} = '0;
		{hsel, exp_rst_n, hsize, ext} = {2'b11, 3'h2, 8'h3C};
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		`CHK("out_rst", 8'hFF, port_out)
		`CHK("oe_rst", 8'h00, port_oe)
		@(posedge hclk);
		xfer(OP_READ_CUR, 1'b0, 8'h00, 8'h00, 1'b0, 8'h3C);
		for (int i = 1; i < 4; i++) begin
			xfer(OP_WRITE, 1'b0, 8'(i), wv[i], 1'b0, 8'h00);
			xfer(OP_READ_CMD, 1'b0, 8'(i), 8'h00, 1'b0, wv[i]);
		end
		`CHK("out", 8'hA5, port_out)
		`CHK("oe", 8'hF0, port_oe)
		xfer(OP_WRITE, 1'b0, `IOX_SEL_SNAP, 8'h00, 1'b0, 8'h00);
		xfer(OP_READ_CUR, 1'b0, 8'h00, 8'h00, 1'b0, ((8'hF0 & 8'hA5) | (8'h0F & ext)) ^ 8'h5A);
		xfer(OP_READ_CMD, 1'b0, `IOX_SEL_OUT, 8'h00, 1'b0, 8'hA5);
		xfer(OP_READ_CUR, 1'b0, 8'h00, 8'h00, 1'b0, 8'hA5);
		addr_strap <= 1'b1;
		xfer(OP_WRITE, 1'b0, `IOX_SEL_OUT, 8'h00, 1'b1, 8'h00);
		xfer(OP_READ_CUR, 1'b1, 8'h00, 8'h00, 1'b0, 8'hA5);
		`CHK("out_kept", 8'hA5, port_out)
		ext <= 8'hC3;
		exp_rst_n <= 1'b0;
		repeat (2) @(posedge hclk);
		exp_rst_n <= 1'b1;
		@(posedge hclk);
		`CHK("out_pin_rst", 8'hFF, port_out)
		`CHK("oe_pin_rst", 8'h00, port_oe)
		xfer(OP_READ_CUR, 1'b1, 8'h00, 8'h00, 1'b0, 8'hC3);
		xfer(OP_READ_CMD, 1'b1, `IOX_SEL_DIR, 8'h00, 1'b0, 8'hFF);
		xfer(OP_READ_CMD, 1'b1, `IOX_SEL_INV, 8'h00, 1'b0, 8'h00);
		close_out();
	end
endmodule
